/* src/srt_defines.svh */
// Purpose: Constants for the 16-bit rollover timer
// Assumes: 250 MHz reference clock, 8-bit register port
// Notes:   Offsets are register indexes on the plain port
`ifndef SRT_DEFINES_SVH
`define SRT_DEFINES_SVH

`define SRT_ADDR_W        3
`define SRT_OFF_CTRL      3'h0
`define SRT_OFF_CNT_LO    3'h1
`define SRT_OFF_CNT_HI    3'h2
`define SRT_OFF_FLAGS     3'h3
`define SRT_OFF_ENABLES   3'h4
`define SRT_OFF_IRQCTL    3'h5
`define SRT_OFF_IRQSTAT   3'h6
`define SRT_OFF_IRQMASK   3'h7

`define SRT_BIT_RUN       0
`define SRT_BIT_CSEL      1
`define SRT_BIT_PS_LO     4
`define SRT_BIT_PS_HI     5
`define SRT_CTRL_MASK     8'h33
`define SRT_BIT_ROLL      0
`define SRT_BIT_PERIPHERAL_IRQ_ENABLE      6
`define SRT_BIT_GIE       7
`define SRT_IRQCTL_MASK   8'hc0

`define SRT_CNT_MAX       16'hffff
`define SRT_CNT_ZERO      16'h0000

// Reference clock, system clock and instruction clock rates in kHz
`define SRT_REF_KHZ       250000
`define SRT_SYS_KHZ       8000
`define SRT_INS_KHZ       2000
`define SRT_SYS_DIV       (`SRT_REF_KHZ / `SRT_SYS_KHZ)
`define SRT_INS_DIV       (`SRT_REF_KHZ / `SRT_INS_KHZ)
`define SRT_DIV_W         7

`endif

/* src/srt_pkg.sv */
// Purpose: Types for the 16-bit rollover timer
// Assumes: srt_defines.svh for constants
// Notes:   Only types live here
package srt_pkg;

	typedef struct packed {
		logic       run;
		logic       csel;
		logic [1:0] ps;
	} srt_ctrl_t;

	typedef struct packed {
		logic [6:0] cnt;
		logic       tick;
	} srt_div_t;

endpackage

/* src/srt_tick_gen.sv */
// Purpose: Count clock ticks at 8 MHz or 2 MHz from the reference clock
// Assumes: Reference clock rate is an exact multiple of 2 MHz; the 8 MHz divide of 31.25 truncates to 31
// Notes:   Stops and restarts at zero while gated off, so Sleep freezes it
`timescale 1ns/1ps
`include "srt_defines.svh"

module srt_tick_gen
(
	// Clock and reset
	input  wire logic REF_CLK_I,
	input  wire logic NRST_I,
	// Control
	input  wire logic run_i,
	input  wire logic csel_i,
	// Tick out
	output logic      tick_o
);

	localparam logic [`SRT_DIV_W-1:0] SYS_LAST = `SRT_DIV_W'(`SRT_SYS_DIV - 1);
	localparam logic [`SRT_DIV_W-1:0] INS_LAST = `SRT_DIV_W'(`SRT_INS_DIV - 1);

	srt_pkg::srt_div_t st_reg;
	srt_pkg::srt_div_t st_next;
	logic [`SRT_DIV_W-1:0] last;

	// Next divider state; held at zero when not running
	always_comb
	begin
		st_next = st_reg;
		last = csel_i ? SYS_LAST : INS_LAST;
		st_next.tick = 1'b0;
		if (!run_i)
		begin
			st_next.cnt = '0;
		end
		else if (st_reg.cnt >= last)
		begin
			st_next.cnt = '0;
			st_next.tick = 1'b1;
		end
		else
		begin
			st_next.cnt = st_reg.cnt + `SRT_DIV_W'(1);
		end
	end

	// State register
	always_ff @(posedge REF_CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign tick_o = st_reg.tick;

endmodule

/* src/srt_timer.sv */
// Purpose: 16-bit up-counting rollover timer with prescaler and interrupt
// Assumes: Register port with one-cycle read latency, one clock domain
// Notes:   Sleep input freezes counting; no wake-up is ever produced
// Functional notes
// - 16-bit counter, read and written as two bytes; writes replace live byte
// - Control bit 0 runs counter; clear stops it and clears gate flip-flop
// - Control bit 1 picks 8 MHz system clock, else 2 MHz instruction clock
// - Bits 5-4 divide selected clock by 1, 2, 4 or 8
// - Prescale counter hidden; cleared by any write to a count byte
// - Counter wraps from FFFFh to 0000h on the next increment
// - Each wrap sets the rollover flag in peripheral flags register one
// - Rollover interrupt needs run, rollover enable, peripheral enable and global enable; status bit with mask set interrupts alone
// - No counting during Sleep and no wake-up event from Sleep
//
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/1ps
`include "srt_defines.svh"

module srt_timer
(
	// Clock and reset
	input  wire logic                   REF_CLK_I,
	input  wire logic                   NRST_I,
	// Register port
	input  wire logic [`SRT_ADDR_W-1:0] ADDR_I,
	input  wire logic [7:0]             WDATA_I,
	input  wire logic                   WR_I,
	input  wire logic                   RD_I,
	output logic      [7:0]             RDATA_O,
	// Device state
	input  wire logic                   SLEEP_I,
	// Interrupt outputs
	output logic                        TMR_IRQ_O,
	output logic                        WAKE_O
);

	typedef struct packed {
		srt_pkg::srt_ctrl_t ctrl;
		logic [15:0]        count;
		logic [2:0]         pre;
		logic               gate;
		logic               roll_flag;
		logic               roll_en;
		logic               peripheral_irq_enable;
		logic               global_irq_enable;
		logic               irq_stat;
		logic               irq_mask;
		logic [7:0]         rdata;
		logic               irq;
		logic               wake;
	} srt_state_t;

	srt_state_t st_reg;
	srt_state_t st_next;
	logic       sleep_meta_reg;
	logic       sleep_sync_reg;
	logic       tick;
	logic       cnt_wr;
	logic       pre_done;
	logic       inc;
	logic       wrap;
	logic       roll_req;

	// Sleep comes from another domain: two flops before use
	always_ff @(posedge REF_CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			sleep_meta_reg <= 1'b0;
			sleep_sync_reg <= 1'b0;
		end
		else
		begin
			sleep_meta_reg <= SLEEP_I;
			sleep_sync_reg <= sleep_meta_reg;
		end
	end

	// Internal clocks only: they stop while asleep
	srt_tick_gen u_tick
	(
		.REF_CLK_I (REF_CLK_I),
		.NRST_I    (NRST_I),
		.run_i     (st_reg.ctrl.run && !sleep_sync_reg),
		.csel_i    (st_reg.ctrl.csel),
		.tick_o    (tick)
	);

	// Prescaler terminal count and rollover detection
	always_comb
	begin
		cnt_wr = WR_I && (ADDR_I == `SRT_OFF_CNT_LO || ADDR_I == `SRT_OFF_CNT_HI);
		unique case (st_reg.ctrl.ps)
			2'h0: pre_done = 1'b1;
			2'h1: pre_done = st_reg.pre[0];
			2'h2: pre_done = &st_reg.pre[1:0];
			2'h3: pre_done = &st_reg.pre;
		endcase
		inc = st_reg.ctrl.run && !sleep_sync_reg && tick && pre_done;
		wrap = inc && !cnt_wr && st_reg.count == `SRT_CNT_MAX;
		roll_req = st_reg.ctrl.run && st_reg.roll_en && st_reg.peripheral_irq_enable && st_reg.global_irq_enable;
	end

	// Next state of the whole block
	always_comb
	begin
		st_next = st_reg;
		st_next.rdata = 8'h00;
		st_next.wake = 1'b0;

		// Prescale counter, hidden from software
		if (!st_reg.ctrl.run || cnt_wr)
			st_next.pre = 3'h0;
		else if (st_reg.ctrl.run && !sleep_sync_reg && tick)
			st_next.pre = pre_done ? 3'h0 : st_reg.pre + 3'h1;

		// Gate flip-flop follows run; stopping clears it
		st_next.gate = st_reg.ctrl.run;

		// Count; stopped counter simply holds
		if (inc)
			st_next.count = st_reg.count + 16'h0001;

		// Register writes; a byte write beats a same-cycle increment
		if (WR_I)
		begin
			unique case (ADDR_I)
				`SRT_OFF_CTRL:
				begin
					st_next.ctrl.run  = WDATA_I[`SRT_BIT_RUN];
					st_next.ctrl.csel = WDATA_I[`SRT_BIT_CSEL];
					st_next.ctrl.ps   = WDATA_I[`SRT_BIT_PS_HI:`SRT_BIT_PS_LO];
				end
				`SRT_OFF_CNT_LO:  st_next.count[7:0]  = WDATA_I;
				`SRT_OFF_CNT_HI:  st_next.count[15:8] = WDATA_I;
				`SRT_OFF_FLAGS:   st_next.roll_flag = WDATA_I[`SRT_BIT_ROLL];
				`SRT_OFF_ENABLES: st_next.roll_en = WDATA_I[`SRT_BIT_ROLL];
				`SRT_OFF_IRQCTL:
				begin
					st_next.peripheral_irq_enable = WDATA_I[`SRT_BIT_PERIPHERAL_IRQ_ENABLE];
					st_next.global_irq_enable  = WDATA_I[`SRT_BIT_GIE];
				end
				`SRT_OFF_IRQSTAT:
				begin
					if (WDATA_I[`SRT_BIT_ROLL])
						st_next.irq_stat = 1'b0;
				end
				`SRT_OFF_IRQMASK: st_next.irq_mask = WDATA_I[`SRT_BIT_ROLL];
			endcase
		end

		// Rollover sets the flags; set wins over a same-cycle clear
		if (wrap)
		begin
			st_next.roll_flag = 1'b1;
			st_next.irq_stat  = 1'b1;
		end

		// Read data, one cycle after the strobe
		if (RD_I)
		begin
			unique case (ADDR_I)
				`SRT_OFF_CTRL:
				begin
					st_next.rdata[`SRT_BIT_RUN] = st_reg.ctrl.run;
					st_next.rdata[`SRT_BIT_CSEL] = st_reg.ctrl.csel;
					st_next.rdata[`SRT_BIT_PS_HI:`SRT_BIT_PS_LO] = st_reg.ctrl.ps;
				end
				`SRT_OFF_CNT_LO:  st_next.rdata = st_reg.count[7:0];
				`SRT_OFF_CNT_HI:  st_next.rdata = st_reg.count[15:8];
				`SRT_OFF_FLAGS:   st_next.rdata[`SRT_BIT_ROLL] = st_reg.roll_flag;
				`SRT_OFF_ENABLES: st_next.rdata[`SRT_BIT_ROLL] = st_reg.roll_en;
				`SRT_OFF_IRQCTL:
				begin
					st_next.rdata[`SRT_BIT_PERIPHERAL_IRQ_ENABLE] = st_reg.peripheral_irq_enable;
					st_next.rdata[`SRT_BIT_GIE]  = st_reg.global_irq_enable;
				end
				`SRT_OFF_IRQSTAT: st_next.rdata[`SRT_BIT_ROLL] = st_reg.irq_stat;
				`SRT_OFF_IRQMASK: st_next.rdata[`SRT_BIT_ROLL] = st_reg.irq_mask;
			endcase
		end

		// Both request paths combine into one level output
		st_next.irq = (roll_req && st_reg.roll_flag)
			|| (st_reg.irq_stat && st_reg.irq_mask);
	end

	// State register
	always_ff @(posedge REF_CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign RDATA_O   = st_reg.rdata;
	assign TMR_IRQ_O = st_reg.irq;
	// Timer is never a wake source; a constant flop keeps the output registered
	assign WAKE_O    = st_reg.wake;

	// Checks
	wrap_sets_flag_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
		wrap |=> st_reg.roll_flag && st_reg.count == `SRT_CNT_ZERO)
		else $error("rollover did not set flag or zero count");

	stop_holds_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
		(!st_reg.ctrl.run && !cnt_wr) |=> st_reg.count == $past(st_reg.count))
		else $error("stopped counter changed");

	sleep_freeze_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
		(sleep_sync_reg && !cnt_wr) |=> $stable(st_reg.count))
		else $error("counter moved during sleep");

	no_wake_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
		!WAKE_O)
		else $error("wake asserted");

	byte_write_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
		(WR_I && ADDR_I == `SRT_OFF_CNT_HI) |=> st_reg.count[15:8] == $past(WDATA_I))
		else $error("high byte write lost");

	pre_clear_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
		cnt_wr |=> st_reg.pre == 3'h0)
		else $error("prescaler not cleared by count write");

	flag_hold_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
		(st_reg.roll_flag && !(WR_I && ADDR_I == `SRT_OFF_FLAGS)) |=> st_reg.roll_flag)
		else $error("rollover flag dropped without write");

	irq_gate_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
		(st_reg.roll_flag && !st_reg.irq_mask && !roll_req) |=> !TMR_IRQ_O)
		else $error("interrupt without all enables");

	div8_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
		(inc && st_reg.ctrl.ps == 2'h3) |-> st_reg.pre == 3'h7)
		else $error("divide by eight step wrong");

	read_back_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
		(RD_I && ADDR_I == `SRT_OFF_CNT_LO) |=> RDATA_O == $past(st_reg.count[7:0]))
		else $error("low byte read mismatch");

	// Register port checks
	lo_write_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
		(WR_I && ADDR_I == `SRT_OFF_CNT_LO) |=> st_reg.count[7:0] == $past(WDATA_I))
		else $error("low byte write lost");

	hi_read_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
		(RD_I && ADDR_I == `SRT_OFF_CNT_HI) |=> RDATA_O == $past(st_reg.count[15:8]))
		else $error("high byte read mismatch");

	rdata_idle_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
		!RD_I |=> RDATA_O == 8'h00)
		else $error("read data not zero outside read");

	run_write_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
		(WR_I && ADDR_I == `SRT_OFF_CTRL)
			|=> st_reg.ctrl.run == $past(WDATA_I[`SRT_BIT_RUN]))
		else $error("run bit write lost");

	csel_write_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
		(WR_I && ADDR_I == `SRT_OFF_CTRL)
			|=> st_reg.ctrl.csel == $past(WDATA_I[`SRT_BIT_CSEL]))
		else $error("clock select write lost");

	ps_write_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
		(WR_I && ADDR_I == `SRT_OFF_CTRL)
			|=> st_reg.ctrl.ps == $past(WDATA_I[`SRT_BIT_PS_HI:`SRT_BIT_PS_LO]))
		else $error("prescale select write lost");

	ctrl_read_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
		(RD_I && ADDR_I == `SRT_OFF_CTRL)
			|=> RDATA_O[`SRT_BIT_RUN] == $past(st_reg.ctrl.run))
		else $error("run bit read mismatch");

	// Count and prescale checks
	inc_step_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
		(inc && !cnt_wr) |=> st_reg.count == $past(st_reg.count) + 16'h0001)
		else $error("count did not step by one");

	gate_follow_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
		st_reg.ctrl.run |=> st_reg.gate)
		else $error("gate flop not set while running");

	gate_clear_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
		!st_reg.ctrl.run |=> !st_reg.gate)
		else $error("gate flop not cleared when stopped");

	stop_no_inc_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
		!st_reg.ctrl.run |-> !inc)
		else $error("increment while stopped");

	sleep_no_inc_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
		sleep_sync_reg |-> !inc)
		else $error("increment during sleep");

	pre_idle_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
		!st_reg.ctrl.run |=> st_reg.pre == 3'h0)
		else $error("prescaler not idle while stopped");

	div_two_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
		(inc && st_reg.ctrl.ps == 2'h1) |-> st_reg.pre[0])
		else $error("divide by two step wrong");

	div_four_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
		(inc && st_reg.ctrl.ps == 2'h2) |-> st_reg.pre[1:0] == 2'h3)
		else $error("divide by four step wrong");

	pre_step_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
		(st_reg.ctrl.run && !sleep_sync_reg && tick && !pre_done && !cnt_wr)
			|=> st_reg.pre == $past(st_reg.pre) + 3'h1)
		else $error("prescaler did not advance on tick");

	// Flag and interrupt checks
	flag_quiet_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
		(!st_reg.roll_flag && !wrap && !(WR_I && ADDR_I == `SRT_OFF_FLAGS))
			|=> !st_reg.roll_flag)
		else $error("rollover flag set without rollover");

	stat_set_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
		wrap |=> st_reg.irq_stat)
		else $error("rollover did not set status bit");

	stat_hold_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
		(st_reg.irq_stat && !(WR_I && ADDR_I == `SRT_OFF_IRQSTAT && WDATA_I[`SRT_BIT_ROLL]))
			|=> st_reg.irq_stat)
		else $error("status bit dropped without clear");

	flag_write_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
		(WR_I && ADDR_I == `SRT_OFF_FLAGS && !wrap)
			|=> st_reg.roll_flag == $past(WDATA_I[`SRT_BIT_ROLL]))
		else $error("rollover flag write lost");

	irq_on_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
		(roll_req && st_reg.roll_flag) |=> TMR_IRQ_O)
		else $error("enabled rollover did not interrupt");

	irq_stat_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
		(st_reg.irq_stat && st_reg.irq_mask) |=> TMR_IRQ_O)
		else $error("unmasked status did not interrupt");

	irq_off_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
		(!(roll_req && st_reg.roll_flag) && !(st_reg.irq_stat && st_reg.irq_mask))
			|=> !TMR_IRQ_O)
		else $error("interrupt without a cause");

	enable_write_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
		(WR_I && ADDR_I == `SRT_OFF_ENABLES)
			|=> st_reg.roll_en == $past(WDATA_I[`SRT_BIT_ROLL]))
		else $error("rollover enable write lost");

	global_write_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
		(WR_I && ADDR_I == `SRT_OFF_IRQCTL)
			|=> st_reg.global_irq_enable == $past(WDATA_I[`SRT_BIT_GIE]))
		else $error("global enable write lost");

endmodule

/* bench/srt_timer_bench.sv */
// Purpose: Self-checking bench for the 16-bit rollover timer
// Assumes: One-cycle read latency, all eight register indexes mapped
// Notes:   Tick phase is not visible, so rate checks allow one count of slack
`timescale 1ns/1ps
`include "srt_defines.svh"

module srt_timer_bench;

	// Bench drive and observation
	logic                   ref_clk = 1'b0;
	logic                   nrst    = 1'b0;
	logic [`SRT_ADDR_W-1:0] addr    = 3'h0;
	logic [7:0]             wdata   = 8'h00;
	logic                   wr_s    = 1'b0;
	logic                   rd_s    = 1'b0;
	logic                   sleep   = 1'b0;
	logic [7:0]             rdata;
	logic                   irq;
	logic                   wake;
	logic [7:0]             rd_v;
	logic [15:0]            cnt_v;
	logic [15:0]            save;
	int                     err_total = 0;
	int                     n_tests   = 0;

	// Enable-gating table: index, value that removes one enable, value that restores it
	logic [2:0] ga [4] = '{3'h4, 3'h5, 3'h5, 3'h0};
	logic [7:0] gf [4] = '{8'h00, 8'h80, 8'h40, 8'h00};
	logic [7:0] gn [4] = '{8'h01, 8'hc0, 8'hc0, 8'h03};

	srt_timer srt_timer_inst (
		.REF_CLK_I (ref_clk),
		.NRST_I    (nrst),
		.ADDR_I    (addr),
		.WDATA_I   (wdata),
		.WR_I      (wr_s),
		.RD_I      (rd_s),
		.RDATA_O   (rdata),
		.SLEEP_I   (sleep),
		.TMR_IRQ_O (irq),
		.WAKE_O    (wake)
	);

	// 250 MHz reference clock
	always #2 ref_clk = ~ref_clk;

	// One-cycle write strobe
	task wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		addr  <= a;
		wdata <= d;
		wr_s  <= 1'b1;
		@(posedge ref_clk);
		wr_s  <= 1'b0;
	endtask

	// Read data is only valid in the cycle after the strobe
	task rd(input logic [2:0] a);
		@(posedge ref_clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge ref_clk);
		rd_s <= 1'b0;
		#1;
		rd_v = rdata;
	endtask

	task rd_cnt();
		rd(`SRT_OFF_CNT_LO);
		cnt_v[7:0] = rd_v;
		rd(`SRT_OFF_CNT_HI);
		cnt_v[15:8] = rd_v;
	endtask

	task chk8(input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp)
		begin
			err_total++;
			$display("wrong value at %0t: expected %h got %h", $time, exp, got);
		end
	endtask

	task chk_rng(input logic [15:0] lo, input logic [15:0] hi, input logic [15:0] got);
		n_tests++;
		if (!(got >= lo && got <= hi) || $isunknown(got))
		begin
			err_total++;
			$display("wrong value at %0t: expected %h..%h got %h", $time, lo, hi, got);
		end
	endtask

	task final_report();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Bounded wait, a hang counts as a mismatch
	task wait_irq(input logic lvl);
		int i;
		for (i = 0; i < 400 && irq !== lvl; i++)
		begin
			@(posedge ref_clk);
			#1;
		end
		if (irq !== lvl)
		begin
			err_total++;
			$display("wrong value at %0t: expected %h got %h", $time, lvl, irq);
			final_report();
		end
	endtask

	// Main sequence
	initial
	begin
		int i;
		int c;
		int p;
		int n;
		repeat (6) @(posedge ref_clk);
		nrst <= 1'b1;
		for (i = 0; i < 8; i++)
		begin
			rd(3'(i));
			chk8(8'h00, rd_v);
		end
		wr(`SRT_OFF_CTRL, 8'hff);
		rd(`SRT_OFF_CTRL);
		chk8(8'h33, rd_v);
		wr(`SRT_OFF_CTRL, 8'h00);
		wr(`SRT_OFF_CNT_LO, 8'ha5);
		wr(`SRT_OFF_CNT_HI, 8'h5a);
		repeat (50) @(posedge ref_clk);
		rd_cnt();
		chk_rng(16'h5aa5, 16'h5aa5, cnt_v);
		$display("test registers done");
		// Every source and prescale pairing, counted over a fixed span
		for (c = 0; c < 2; c++)
			for (p = 0; p < 4; p++)
			begin
				wr(`SRT_OFF_CNT_LO, 8'h00);
				wr(`SRT_OFF_CNT_HI, 8'h00);
				wr(`SRT_OFF_CTRL, {2'h0, p[1:0], 2'h0, c[0], 1'b1});
				repeat (2000) @(posedge ref_clk);
				wr(`SRT_OFF_CTRL, 8'h00);
				rd_cnt();
				n = 2000 / ((c ? `SRT_SYS_DIV : `SRT_INS_DIV) << p);
				chk_rng(16'(n - 1), 16'(n + 1), cnt_v);
			end
		save = cnt_v;
		repeat (300) @(posedge ref_clk);
		rd_cnt();
		chk_rng(save, save, cnt_v);
		$display("test rate done");
		// Rollover with all enables on
		wr(`SRT_OFF_CNT_LO, 8'h00);
		wr(`SRT_OFF_CNT_HI, 8'h00);
		wr(`SRT_OFF_FLAGS, 8'h00);
		wr(`SRT_OFF_ENABLES, 8'h01);
		wr(`SRT_OFF_IRQCTL, 8'hc0);
		wr(`SRT_OFF_CNT_LO, 8'hfe);
		wr(`SRT_OFF_CNT_HI, 8'hff);
		wr(`SRT_OFF_CTRL, 8'h03);
		wait_irq(1'b1);
		rd(`SRT_OFF_FLAGS);
		chk8(8'h01, rd_v);
		rd(`SRT_OFF_IRQSTAT);
		chk8(8'h01, rd_v);
		rd_cnt();
		chk_rng(16'h0000, 16'h0010, cnt_v);
		for (i = 0; i < 4; i++)
		begin
			wr(ga[i], gf[i]);
			repeat (3) @(posedge ref_clk);
			#1;
			chk8(8'h00, {7'h00, irq});
			wr(ga[i], gn[i]);
			repeat (3) @(posedge ref_clk);
			#1;
			chk8(8'h01, {7'h00, irq});
		end
		repeat (200) @(posedge ref_clk);
		rd(`SRT_OFF_FLAGS);
		chk8(8'h01, rd_v);
		wr(`SRT_OFF_FLAGS, 8'h00);
		repeat (3) @(posedge ref_clk);
		#1;
		chk8(8'h00, {7'h00, irq});
		// Sticky status path: write zero keeps it, write one clears it
		wr(`SRT_OFF_ENABLES, 8'h00);
		wr(`SRT_OFF_IRQMASK, 8'h01);
		wr(`SRT_OFF_IRQSTAT, 8'h00);
		repeat (3) @(posedge ref_clk);
		#1;
		chk8(8'h01, {7'h00, irq});
		wr(`SRT_OFF_IRQSTAT, 8'h01);
		wait_irq(1'b0);
		rd(`SRT_OFF_IRQSTAT);
		chk8(8'h00, rd_v);
		$display("test rollover done");
		// Sleep freezes the count and never wakes
		@(posedge ref_clk);
		sleep <= 1'b1;
		repeat (5) @(posedge ref_clk);
		rd_cnt();
		save = cnt_v;
		repeat (500) @(posedge ref_clk);
		rd_cnt();
		chk_rng(save, save, cnt_v);
		chk8(8'h00, {7'h00, wake});
		@(posedge ref_clk);
		sleep <= 1'b0;
		repeat (300) @(posedge ref_clk);
		rd_cnt();
		chk_rng(save + 16'h0001, save + 16'h0014, cnt_v);
		$display("test sleep done");
		final_report();
	end

endmodule
